// file: common/tcr_defines.svh
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define TCR_IDX_CTRL     8'hc8
`define TCR_IDX_RLD_LO   8'hca
`define TCR_IDX_RLD_HI   8'hcb
`define TCR_IDX_CNT_LO   8'hcc
`define TCR_IDX_CNT_HI   8'hcd
`define TCR_IDX_INT_STAT 8'he0
`define TCR_IDX_INT_CLR  8'he1
`define TCR_IDX_INT_EN   8'he2

// ----------------------------------------
// control register bit positions
// ----------------------------------------
`define TCR_B_OVF    7
`define TCR_B_TRIG   6
`define TCR_B_RXSEL  5
`define TCR_B_TXSEL  4
`define TCR_B_TRIGEN 3
`define TCR_B_RUN    2
`define TCR_B_CTSEL  1
`define TCR_B_CPSEL  0

// ----------------------------------------
// event bits of status, clear and enable
// ----------------------------------------
`define TCR_EV_OVF   0
`define TCR_EV_TRIG  1

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define TCR_CTRL_RST 8'h00
`define TCR_WORD_RST 16'h0000
`define TCR_CNT_MAX  16'hffff
`define TCR_CNT_ONE  16'h0001

`endif

// file: common/tcr_pkg.sv
package tcr_pkg;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    typedef enum logic [1:0] {
        TCR_IDLE = 2'b00,
        TCR_WR   = 2'b01,
        TCR_RD1  = 2'b10,
        TCR_RD2  = 2'b11
    } tcr_bus_state_t;

    typedef struct packed {
        tcr_bus_state_t st;
        logic [7:0]     idx;
        logic [31:0]    hrdata;
    } tcr_slave_t;

    // ----------------------------------------
    // edge detector
    // ----------------------------------------
    typedef struct packed {
        logic prev;
    } tcr_fall_t;

    // ----------------------------------------
    // timer core
    // ----------------------------------------
    typedef struct packed {
        logic        ovfFlag;
        logic        trigFlag;
        logic        rxSel;
        logic        txSel;
        logic        trigEn;
        logic        run;
        logic        ctSel;
        logic        cpSel;
        logic [15:0] count;
        logic [15:0] reload;
        logic        div;
        logic [1:0]  status;
        logic [1:0]  intEn;
        logic        rxTick;
        logic        txTick;
    } tcr_timer_t;

endpackage : tcr_pkg

// file: common/tcr_reg_if.sv
`timescale 1ns/100ps
`default_nettype none

interface tcr_reg_if;
    logic       wrEn;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport slave (output wrEn, output idx, output wdata, input rdata);
    modport regs  (input wrEn, input idx, input wdata, output rdata);
endinterface : tcr_reg_if

`default_nettype wire

// file: hdl/tcr_fall_det.sv
`timescale 1ns/100ps
`default_nettype none

module tcr_fall_det (
    input  wire logic ref_clk,  // system clock
    input  wire logic rst_n,    // sync reset
    input  wire logic pin,      // synchronous pin level
    output logic      fall      // one-cycle falling edge
);
    tcr_pkg::tcr_fall_t q, n;

    always_comb begin
        n      = q;
        n.prev = pin;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // a reset-low sample means a pin held low through reset is no edge
    assign fall = q.prev & ~pin;

    property p_fall_pair;
        @(posedge ref_clk) disable iff (!rst_n)
        fall |-> $past(pin) && !pin;
    endproperty
    a_fall_pair: assert property (p_fall_pair) else $error("fall without high-low pair");

endmodule : tcr_fall_det

`default_nettype wire

// file: hdl/tcr_ahb_slave.sv
`timescale 1ns/100ps
`default_nettype none

module tcr_ahb_slave (
    input  wire logic        ref_clk,   // system clock
    input  wire logic        rst_n,     // sync reset
    input  wire logic        hsel,      // slave select
    input  wire logic [31:0] haddr,     // byte address
    input  wire logic [1:0]  htrans,    // transfer type
    input  wire logic        hwrite,    // write
    input  wire logic [31:0] hwdata,    // write data
    input  wire logic        hready,    // bus ready
    output logic             hreadyout, // slave ready
    output logic [31:0]      hrdata,    // read data
    tcr_reg_if.slave         bus        // register side
);
    tcr_pkg::tcr_slave_t q, n;
    logic take;

    always_comb begin
        n    = q;
        take = hsel & htrans[1] & hready;
        unique case (q.st)
            tcr_pkg::TCR_RD1: begin
                // one wait state so a read never sees a stale write
                n.hrdata = {24'h000000, bus.rdata};
                n.st     = tcr_pkg::TCR_RD2;
            end
            tcr_pkg::TCR_IDLE, tcr_pkg::TCR_WR, tcr_pkg::TCR_RD2: begin
                n.st = tcr_pkg::TCR_IDLE;
                if (take) begin
                    n.idx = haddr[9:2];
                    n.st  = hwrite ? tcr_pkg::TCR_WR : tcr_pkg::TCR_RD1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign hreadyout = (q.st != tcr_pkg::TCR_RD1);
    assign hrdata    = q.hrdata;
    assign bus.wrEn  = (q.st == tcr_pkg::TCR_WR);
    assign bus.idx   = q.idx;
    assign bus.wdata = hwdata[7:0];

endmodule : tcr_ahb_slave

`default_nettype wire

// file: hdl/tcr_timer.sv
// Functional notes
// - overflow flag bit 7 set on count overflow unless a serial select is 1
// - trigger flag bit 6 set when an enabled trigger edge captures or reloads
// - receive select bit 5: 0 picks timer1 overflow, 1 this overflow
// - transmit select bit 4: 0 picks timer1 overflow, 1 this overflow
// - trigger edge acts only with pin enable set and both serial selects 0
// - run bit 2 stops the count at 0 and lets it count at 1
// - control bits 7 to 2 read and write by software, reset to 0
// - counter select: 0 counts every two clocks, 1 on count pin falls
// - capture select: 0 reloads, 1 captures; serial modes force overflow reload
// - reload value and count are writable byte pairs resetting to zero
`timescale 1ns/100ps
`default_nettype none
`include "tcr_defines.svh"

module tcr_timer (
    input  wire logic        ref_clk,    // 40 MHz system clock
    input  wire logic        rst_n,      // sync reset
    input  wire logic        hsel,       // ahb select
    input  wire logic [31:0] haddr,      // ahb address
    input  wire logic [1:0]  htrans,     // ahb transfer type
    input  wire logic        hwrite,     // ahb write
    input  wire logic [2:0]  hsize,      // ahb size, words only
    input  wire logic [31:0] hwdata,     // ahb write data
    input  wire logic        hready,     // ahb bus ready
    output logic             hreadyout,  // ahb slave ready
    output logic             hresp,      // ahb response, always okay
    output logic [31:0]      hrdata,     // ahb read data
    input  wire logic        countPin,   // external count input
    input  wire logic        triggerPin, // external trigger input
    input  wire logic        timer1Ovf,  // timer1 overflow pulse
    output logic             rxClkTick,  // serial receive clock pulse
    output logic             txClkTick,  // serial transmit clock pulse
    output logic             irq         // level interrupt
);
    // ----------------------------------------
    // bus slave and pin edges
    // ----------------------------------------
    tcr_reg_if bus ();

    tcr_ahb_slave u_slave (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .bus       (bus)
    );

    logic cntFall;
    logic trigFall;

    tcr_fall_det u_cnt_edge (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (countPin),
        .fall    (cntFall)
    );

    tcr_fall_det u_trig_edge (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (triggerPin),
        .fall    (trigFall)
    );

    // ----------------------------------------
    // timer state
    // ----------------------------------------
    tcr_pkg::tcr_timer_t q, n;
    logic       baud;
    logic       tick;
    logic       incr;
    logic       wrap;
    logic       trigEvt;
    logic       capEvt;
    logic       ovfSet;
    logic       ctrlWr;
    logic [1:0] evClr;
    logic [7:0] wd;

    always_comb begin
        n       = q;
        wd      = bus.wdata;
        baud    = q.rxSel | q.txSel;
        n.div   = ~q.div;
        tick    = q.ctSel ? cntFall : q.div;
        incr    = q.run & tick;
        wrap    = incr & (q.count == `TCR_CNT_MAX);
        trigEvt = q.trigEn & ~baud & trigFall;
        capEvt  = trigEvt & q.cpSel;
        ovfSet  = wrap & ~baud;
        ctrlWr  = bus.wrEn & (bus.idx == `TCR_IDX_CTRL);
        evClr   = 2'b00;

        // count path: serial modes ignore capture select
        if (incr) begin
            if (wrap && (baud || !q.cpSel)) begin
                n.count = q.reload;
            end else begin
                n.count = q.count + `TCR_CNT_ONE;
            end
        end
        if (trigEvt && !q.cpSel) begin
            n.count = q.reload;
        end
        if (capEvt) begin
            n.reload = q.count;
        end

        // serial bit clocks, registered
        n.rxTick = q.rxSel ? wrap : timer1Ovf;
        n.txTick = q.txSel ? wrap : timer1Ovf;

        // software writes override the hardware count this cycle
        if (bus.wrEn) begin
            case (bus.idx)
                `TCR_IDX_CTRL: begin
                    n.ovfFlag = wd[`TCR_B_OVF];
                    n.trigFlag = wd[`TCR_B_TRIG];
                    n.rxSel   = wd[`TCR_B_RXSEL];
                    n.txSel   = wd[`TCR_B_TXSEL];
                    n.trigEn  = wd[`TCR_B_TRIGEN];
                    n.run     = wd[`TCR_B_RUN];
                    n.ctSel   = wd[`TCR_B_CTSEL];
                    n.cpSel   = wd[`TCR_B_CPSEL];
                end
                `TCR_IDX_RLD_LO: n.reload[7:0]  = wd;
                `TCR_IDX_RLD_HI: n.reload[15:8] = wd;
                `TCR_IDX_CNT_LO: n.count[7:0]   = wd;
                `TCR_IDX_CNT_HI: n.count[15:8]  = wd;
                `TCR_IDX_INT_CLR: begin
                    evClr = wd[1:0];
                end
                `TCR_IDX_INT_EN: begin
                    n.intEn = wd[1:0];
                end
                default: begin
                    // unmapped and read-only: write ignored
                end
            endcase
        end

        // hardware set wins over a software clear in the same cycle
        if (ovfSet) begin
            n.ovfFlag = 1'b1;
        end
        if (trigEvt) begin
            n.trigFlag = 1'b1;
        end
        n.status = q.status & ~evClr;
        if (ovfSet) begin
            n.status[`TCR_EV_OVF] = 1'b1;
        end
        if (trigEvt) begin
            n.status[`TCR_EV_TRIG] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        case (bus.idx)
            `TCR_IDX_CTRL: begin
                bus.rdata = {q.ovfFlag, q.trigFlag, q.rxSel, q.txSel,
                             q.trigEn, q.run, q.ctSel, q.cpSel};
            end
            `TCR_IDX_RLD_LO:   bus.rdata = q.reload[7:0];
            `TCR_IDX_RLD_HI:   bus.rdata = q.reload[15:8];
            `TCR_IDX_CNT_LO:   bus.rdata = q.count[7:0];
            `TCR_IDX_CNT_HI:   bus.rdata = q.count[15:8];
            `TCR_IDX_INT_STAT: bus.rdata = {6'h00, q.status};
            `TCR_IDX_INT_EN:   bus.rdata = {6'h00, q.intEn};
            default:           bus.rdata = 8'h00;
        endcase
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hresp     = 1'b0;
    assign rxClkTick = q.rxTick;
    assign txClkTick = q.txTick;
    assign irq       = |(q.status & q.intEn);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_ovf_set;
        ovfSet |=> q.ovfFlag && q.status[`TCR_EV_OVF];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_ovf_cause;
        $rose(q.ovfFlag) |-> $past(ovfSet) || $past(ctrlWr);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("overflow flag rose alone");

    property p_trig_set;
        trigEvt |=> q.trigFlag && q.status[`TCR_EV_TRIG];
    endproperty
    a_trig_set: assert property (p_trig_set) else $error("trigger flag not set");

    property p_rx_sel;
        q.rxSel && wrap || !q.rxSel && timer1Ovf |=> rxClkTick;
    endproperty
    a_rx_sel: assert property (p_rx_sel) else $error("receive clock source wrong");

    property p_tx_sel;
        q.txSel && !wrap || !q.txSel && !timer1Ovf |=> !txClkTick;
    endproperty
    a_tx_sel: assert property (p_tx_sel) else $error("transmit clock source wrong");

    property p_trig_gate;
        trigEvt |-> q.trigEn && !baud && $past(triggerPin) && !triggerPin;
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger acted while gated");

    // an enabled trigger reload may still move a stopped count
    property p_stop;
        !q.run && !bus.wrEn && !trigEvt |=> $stable(q.count);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");

    property p_ctrl_rst;
        disable iff (1'b0)
        !rst_n |=> {q.ovfFlag, q.trigFlag, q.rxSel, q.txSel, q.trigEn, q.run} == 6'h00;
    endproperty
    a_ctrl_rst: assert property (p_ctrl_rst) else $error("control not cleared");

    sequence s_timer_run;
        q.run && !q.ctSel && !bus.wrEn && !trigEvt && q.count != `TCR_CNT_MAX;
    endsequence

    property p_rate;
        s_timer_run ##1 s_timer_run |=> q.count == $past(q.count, 2) + `TCR_CNT_ONE;
    endproperty
    a_rate: assert property (p_rate) else $error("timer rate not every two clocks");

    property p_capture;
        capEvt && !bus.wrEn |=> q.reload == $past(q.count);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_reload;
        wrap && (baud || !q.cpSel) && !bus.wrEn |=> q.count == $past(q.reload);
    endproperty
    a_reload: assert property (p_reload) else $error("overflow reload missed");

    property p_word_rst;
        disable iff (1'b0)
        !rst_n |=> q.count == `TCR_WORD_RST && q.reload == `TCR_WORD_RST;
    endproperty
    a_word_rst: assert property (p_word_rst) else $error("count or reload not zero");

endmodule : tcr_timer

`default_nettype wire

// file: verif/tcr_partner.sv
`timescale 1ns/100ps
`default_nettype none

module tcr_partner (
    input  wire logic ref_clk,    // system clock
    output logic      countPin,   // count input of the timer
    output logic      triggerPin, // trigger input of the timer
    output logic      timer1Ovf,  // timer1 overflow pulse
    input  wire logic rxClkTick,  // receive clock pulse
    input  wire logic txClkTick   // transmit clock pulse
);
    int rxN;
    int txN;

    initial begin
        countPin = 1'b1;
        triggerPin = 1'b1;
        timer1Ovf = 1'b0;
        rxN = 0;
        txN = 0;
    end

    // ----------------------------------------
    // serial bit clock consumer
    // ----------------------------------------
    // sampled mid-cycle, away from the edge that launches a pulse
    always @(negedge ref_clk) begin
        if (rxClkTick === 1'b1) rxN <= rxN + 1;
        if (txClkTick === 1'b1) txN <= txN + 1;
    end

    // ----------------------------------------
    // pin stimulus: 0 count, 1 trigger, 2 timer1
    // ----------------------------------------
    // pins idle high; low for two clocks so one sample pair sees one fall
    task automatic fall(input int which);
        @(posedge ref_clk);
        timer1Ovf <= (which == 2);
        triggerPin <= (which != 1);
        countPin <= (which != 0);
        repeat ((which == 2) ? 1 : 2) @(posedge ref_clk);
        timer1Ovf <= 1'b0;
        triggerPin <= 1'b1;
        countPin <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask : fall
endmodule : tcr_partner

`default_nettype wire

// file: verif/tcr_timer_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcr_defines.svh"

module tcr_timer_test;
    logic        ref_clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        countPin;
    logic        triggerPin;
    logic        timer1Ovf;
    logic        rxClkTick;
    logic        txClkTick;
    logic        irq;
    logic        rdData;
    logic [7:0]  expQ[$];
    logic [31:0] rng;
    logic [7:0]  v;
    logic [7:0]  idxs[7];
    int          n_fail;
    int          cmp_count;
    int          r0;
    int          t0;

    tcr_timer dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .countPin(countPin),
        .triggerPin(triggerPin), .timer1Ovf(timer1Ovf), .rxClkTick(rxClkTick),
        .txClkTick(txClkTick), .irq(irq)
    );

    tcr_partner u_far (
        .ref_clk(ref_clk), .countPin(countPin), .triggerPin(triggerPin),
        .timer1Ovf(timer1Ovf), .rxClkTick(rxClkTick), .txClkTick(txClkTick)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction : rnd

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // reads note their expected byte; the monitor below compares it
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] val);
        if (!wr) expQ.push_back(val);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h000000, idx, 2'b00};
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, val};
        rdData <= !wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rdData <= 1'b0;
    endtask : bus

    // taken at the edge that ends the data phase, as the master does
    always @(posedge ref_clk) begin
        if (rdData === 1'b1 && hreadyout === 1'b1 && expQ.size() > 0) begin
            chk("read data", hrdata, {24'h000000, expQ.pop_front()});
            chk("response", hresp, 1'b0);
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        stop_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        rdData = 1'b0;
        rst_n = 1'b0;
        rng = 32'h2c79;
        n_fail = 0;
        cmp_count = 0;
        idxs = '{`TCR_IDX_CTRL, `TCR_IDX_RLD_LO, `TCR_IDX_RLD_HI, `TCR_IDX_CNT_LO,
                 `TCR_IDX_CNT_HI, `TCR_IDX_INT_EN, 8'h10};
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (idxs[i]) bus(0, idxs[i], 8'h00);
        $display("test reset done");
        // run bit kept low so the count bytes stay put
        v = rnd() & 8'hf8;
        bus(1, `TCR_IDX_CTRL, v);
        bus(0, `TCR_IDX_CTRL, v);
        for (int i = 1; i < 5; i++) begin
            v = rnd();
            bus(1, idxs[i], v);
            bus(0, idxs[i], v);
        end
        bus(1, `TCR_IDX_INT_EN, 8'h03);
        bus(0, `TCR_IDX_INT_EN, 8'h03);
        $display("test registers done");
        bus(1, `TCR_IDX_CTRL, 8'h00);
        bus(1, `TCR_IDX_RLD_LO, 8'h00);
        bus(1, `TCR_IDX_RLD_HI, 8'h12);
        bus(1, `TCR_IDX_CNT_LO, 8'hfe);
        bus(1, `TCR_IDX_CNT_HI, 8'hff);
        bus(1, `TCR_IDX_CTRL, 8'h04);
        repeat (20) @(posedge ref_clk);
        bus(0, `TCR_IDX_CTRL, 8'h84);
        bus(0, `TCR_IDX_CNT_HI, 8'h12);
        bus(0, `TCR_IDX_INT_STAT, 8'h01);
        chk("irq", irq, 1'b1);
        bus(1, `TCR_IDX_INT_CLR, 8'h01);
        bus(0, `TCR_IDX_INT_STAT, 8'h00);
        chk("irq", irq, 1'b0);
        bus(0, `TCR_IDX_CTRL, 8'h84);
        bus(1, `TCR_IDX_CTRL, 8'h00);
        bus(1, `TCR_IDX_CNT_LO, 8'h55);
        repeat (10) @(posedge ref_clk);
        bus(0, `TCR_IDX_CNT_LO, 8'h55);
        $display("test overflow done");
        bus(1, `TCR_IDX_CNT_LO, 8'h00);
        bus(1, `TCR_IDX_CNT_HI, 8'h00);
        bus(1, `TCR_IDX_CTRL, 8'h06);
        repeat (5) u_far.fall(0);
        bus(0, `TCR_IDX_CNT_LO, 8'h05);
        bus(1, `TCR_IDX_CTRL, 8'h0f);
        u_far.fall(1);
        bus(0, `TCR_IDX_RLD_LO, 8'h05);
        bus(0, `TCR_IDX_CTRL, 8'h4f);
        bus(0, `TCR_IDX_INT_STAT, 8'h02);
        chk("irq", irq, 1'b1);
        bus(1, `TCR_IDX_CTRL, 8'h07);
        bus(1, `TCR_IDX_INT_CLR, 8'h02);
        u_far.fall(1);
        bus(0, `TCR_IDX_CTRL, 8'h07);
        bus(0, `TCR_IDX_INT_STAT, 8'h00);
        bus(1, `TCR_IDX_RLD_LO, 8'h09);
        bus(1, `TCR_IDX_CTRL, 8'h0e);
        u_far.fall(1);
        bus(0, `TCR_IDX_CNT_LO, 8'h09);
        bus(0, `TCR_IDX_CTRL, 8'h4e);
        $display("test pins done");
        bus(1, `TCR_IDX_CTRL, 8'h00);
        bus(1, `TCR_IDX_INT_CLR, 8'h03);
        r0 = u_far.rxN;
        t0 = u_far.txN;
        repeat (3) u_far.fall(2);
        chk("rx ticks", u_far.rxN - r0, 3);
        chk("tx ticks", u_far.txN - t0, 3);
        bus(1, `TCR_IDX_CNT_LO, 8'hff);
        bus(1, `TCR_IDX_CNT_HI, 8'hff);
        r0 = u_far.rxN;
        t0 = u_far.txN;
        bus(1, `TCR_IDX_CTRL, 8'h3c);
        repeat (10) @(posedge ref_clk);
        u_far.fall(1);
        // own overflow clocks the port but raises no flag, trigger ignored
        bus(0, `TCR_IDX_CTRL, 8'h3c);
        bus(0, `TCR_IDX_INT_STAT, 8'h00);
        chk("rx ticks", u_far.rxN - r0, 1);
        chk("tx ticks", u_far.txN - t0, 1);
        $display("test serial done");
        // capture mode wraps to zero; one serial select alone
        bus(1, `TCR_IDX_CTRL, 8'h00);
        bus(1, `TCR_IDX_CNT_LO, 8'hff);
        bus(1, `TCR_IDX_CNT_HI, 8'hff);
        bus(1, `TCR_IDX_CTRL, 8'h07);
        u_far.fall(0);
        bus(0, `TCR_IDX_CNT_LO, 8'h00);
        bus(0, `TCR_IDX_CTRL, 8'h87);
        bus(0, `TCR_IDX_INT_STAT, 8'h01);
        r0 = u_far.rxN;
        t0 = u_far.txN;
        bus(1, `TCR_IDX_CTRL, 8'h27);
        repeat (2) u_far.fall(2);
        chk("rx ticks", u_far.rxN - r0, 0);
        chk("tx ticks", u_far.txN - t0, 2);
        $display("test modes done");
        // reset again with dirty state
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        bus(0, `TCR_IDX_CTRL, 8'h00);
        bus(0, `TCR_IDX_CNT_LO, 8'h00);
        bus(0, `TCR_IDX_INT_STAT, 8'h00);
        chk("irq", irq, 1'b0);
        $display("test second reset done");
        stop_test();
    end
endmodule : tcr_timer_test

`default_nettype wire
